//--- src/serial_frame_codec.sv
`timescale 1ns/1ps
module serial_frame_codec
	import frame_pkg::*;
#(
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] pay_data,
	input wire logic pay_last,
	input wire logic pay_valid,
	output logic pay_ready,
	input wire logic can_powered,
	input wire logic boot_done,
	input wire logic usb_attached,
	output logic link_active,
	output logic serial_tx,
	output logic frame_sent
);
	initial begin
		if (BIT_CYCLES < 2)
			$error("clock too slow for the baud rate");
	end

	// CRC16 step, reflected form of 0x8005
	function automatic logic [15:0] crc_step(input logic [15:0] crc,
		input logic [7:0] din);
		logic [15:0] c;
		c = crc ^ {8'h00, din};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		return c;
	endfunction

	function automatic logic needs_escape(input logic [7:0] b);
		return b == FLAG_BYTE || b == ESCAPE_BYTE;
	endfunction

	// Pin-side inputs through two flip-flops
	logic [1:0] pwr_sync_r, boot_sync_r, usb_sync_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pwr_sync_r <= 2'h0;
			boot_sync_r <= 2'h0;
			usb_sync_r <= 2'h0;
		end else begin
			pwr_sync_r <= {pwr_sync_r[0], can_powered};
			boot_sync_r <= {boot_sync_r[0], boot_done};
			usb_sync_r <= {usb_sync_r[0], usb_attached};
		end
	end

	// Activation: USB must arrive after boot on CAN supply; a cable present
	// at boot time means storage mode, so it never arms the link.
	logic seen_usb_before_r, seen_usb_before_nxt;
	logic active_r, active_nxt;
	always_comb begin
		seen_usb_before_nxt = seen_usb_before_r;
		if (!boot_sync_r[1] && usb_sync_r[1])
			seen_usb_before_nxt = 1'b1;
		active_nxt = pwr_sync_r[1] && boot_sync_r[1] && usb_sync_r[1] &&
			!seen_usb_before_r;
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			seen_usb_before_r <= 1'b0;
			active_r <= 1'b0;
		end else begin
			seen_usb_before_r <= seen_usb_before_nxt;
			active_r <= active_nxt;
		end
	end
	assign link_active = active_r;

	// Payload buffer; its ready stalls the producer
	pay_word_s fifo_in, fifo_out;
	logic fifo_out_valid, fifo_pop;
	// Payload goes out byte-stuffed and in order: app id first, fields as given
	assign fifo_in = '{last: pay_last, data: pay_data};
	word_fifo #(.WIDTH($bits(pay_word_s)), .DEPTH(FIFO_WORDS)) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_data(fifo_in),
		.in_valid(pay_valid),
		.in_ready(pay_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	// Byte serialiser: 8N1, LSB first
	logic [9:0] sh_r, sh_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [15:0] baud_r, baud_nxt;
	logic busy_r, busy_nxt;
	logic tx_r, tx_nxt;
	logic load;
	logic [7:0] load_byte;
	always_comb begin
		sh_nxt = sh_r;
		bit_cnt_nxt = bit_cnt_r;
		baud_nxt = baud_r;
		busy_nxt = busy_r;
		tx_nxt = tx_r;
		if (load) begin
			sh_nxt = {1'b1, load_byte, 1'b0};
			bit_cnt_nxt = 4'(BITS_PER_CHAR - 1);
			baud_nxt = 16'(BIT_CYCLES - 1);
			busy_nxt = 1'b1;
			tx_nxt = 1'b0;
		end else if (busy_r) begin
			if (baud_r == 16'h0000) begin
				baud_nxt = 16'(BIT_CYCLES - 1);
				if (bit_cnt_r == 4'h0) begin
					busy_nxt = 1'b0;
					tx_nxt = 1'b1;
				end else begin
					sh_nxt = {1'b1, sh_r[9:1]};
					tx_nxt = sh_r[1];
					bit_cnt_nxt = bit_cnt_r - 4'h1;
				end
			end else begin
				baud_nxt = baud_r - 16'h0001;
			end
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sh_r <= 10'h3FF;
			bit_cnt_r <= 4'h0;
			baud_r <= 16'h0000;
			busy_r <= 1'b0;
			tx_r <= 1'b1;
		end else begin
			sh_r <= sh_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			baud_r <= baud_nxt;
			busy_r <= busy_nxt;
			tx_r <= tx_nxt;
		end
	end
	assign serial_tx = tx_r;

	// Framer: flag, stuffed payload, stuffed CRC high/low, flag
	tx_state_e st_r, st_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic esc_pend_r, esc_pend_nxt;
	logic [7:0] esc_byte_r, esc_byte_nxt;
	logic sent_r, sent_nxt;
	logic [7:0] cur_byte;
	logic can_load;
	logic load_q_r;
	// One-cycle hold-off after a load so busy_r has settled before the next
	assign can_load = !busy_r && !load_q_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			load_q_r <= 1'b0;
		else
			load_q_r <= load;
	end

	always_comb begin
		st_nxt = st_r;
		crc_nxt = crc_r;
		esc_pend_nxt = esc_pend_r;
		esc_byte_nxt = esc_byte_r;
		sent_nxt = 1'b0;
		load = 1'b0;
		load_byte = FLAG_BYTE;
		fifo_pop = 1'b0;
		cur_byte = 8'h00;
		case (st_r)
			ST_IDLE: begin
				if (active_r && fifo_out_valid && can_load) begin
					load = 1'b1;
					load_byte = FLAG_BYTE;
					crc_nxt = CRC_INIT;
					st_nxt = ST_BODY;
				end
			end
			ST_BODY, ST_CRC_HI, ST_CRC_LO: begin
				if (can_load && esc_pend_r) begin
					load = 1'b1;
					load_byte = esc_byte_r ^ ESCAPE_MASK;
					esc_pend_nxt = 1'b0;
				end else if (can_load && st_r == ST_BODY && fifo_out_valid) begin
					fifo_pop = 1'b1;
					cur_byte = fifo_out.data;
					crc_nxt = crc_step(crc_r, cur_byte);
					if (fifo_out.last)
						st_nxt = ST_CRC_HI;
				end else if (can_load && st_r == ST_CRC_HI) begin
					cur_byte = crc_r[15:8];
					st_nxt = ST_CRC_LO;
				end else if (can_load && st_r == ST_CRC_LO) begin
					cur_byte = crc_r[7:0];
					st_nxt = ST_CLOSE;
				end
				if (fifo_pop || (can_load && !esc_pend_r &&
					st_r != ST_BODY)) begin
					load = 1'b1;
					if (needs_escape(cur_byte)) begin
						load_byte = ESCAPE_BYTE;
						esc_pend_nxt = 1'b1;
						esc_byte_nxt = cur_byte;
					end else begin
						load_byte = cur_byte;
					end
				end
			end
			ST_CLOSE: begin
				if (can_load && esc_pend_r) begin
					load = 1'b1;
					load_byte = esc_byte_r ^ ESCAPE_MASK;
					esc_pend_nxt = 1'b0;
				end else if (can_load) begin
					load = 1'b1;
					load_byte = FLAG_BYTE;
					sent_nxt = 1'b1;
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
			crc_r <= CRC_INIT;
			esc_pend_r <= 1'b0;
			esc_byte_r <= 8'h00;
			sent_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			crc_r <= crc_nxt;
			esc_pend_r <= esc_pend_nxt;
			esc_byte_r <= esc_byte_nxt;
			sent_r <= sent_nxt;
		end
	end
	assign frame_sent = sent_r;

	// Checks
	a_esc_follows: assert property (@(posedge clock) disable iff (sys_rst)
		load && load_byte == ESCAPE_BYTE && st_r != ST_IDLE |=>
		esc_pend_r && needs_escape(esc_byte_r))
		else $error("escape byte not followed by a masked byte");
	a_no_inner_flag: assert property (@(posedge clock) disable iff (sys_rst)
		load && (st_r == ST_BODY || st_r == ST_CRC_HI || st_r == ST_CRC_LO)
		|-> load_byte != FLAG_BYTE)
		else $error("flag value inside a frame");
	a_open_flag: assert property (@(posedge clock) disable iff (sys_rst)
		st_r == ST_IDLE && load |-> load_byte == FLAG_BYTE)
		else $error("frame did not open with the flag");
	a_start_bit: assert property (@(posedge clock) disable iff (sys_rst)
		load |=> !serial_tx [*2])
		else $error("start bit too short");
	a_link_gate: assert property (@(posedge clock) disable iff (sys_rst)
		st_r == ST_IDLE && !active_r |-> !load)
		else $error("frame started while link inactive");
	a_crc_order: assert property (@(posedge clock) disable iff (sys_rst)
		st_r == ST_CRC_HI && st_nxt == ST_CRC_LO |-> cur_byte == crc_r[15:8])
		else $error("check field high byte not first");
	a_crc_fresh: assert property (@(posedge clock) disable iff (sys_rst)
		st_r == ST_IDLE && load |=> crc_r == CRC_INIT)
		else $error("check not cleared at frame start");
	a_sent_pulse: assert property (@(posedge clock) disable iff (sys_rst)
		frame_sent |=> !frame_sent)
		else $error("frame_sent longer than one cycle");
endmodule

//--- include/frame_pkg.sv
package frame_pkg;
	// Link timing
	localparam int unsigned CLOCK_HZ = 20000000;
	localparam int unsigned BAUD_RATE = 115200;
	localparam int unsigned BIT_CYCLES = CLOCK_HZ / BAUD_RATE;
	localparam int unsigned BITS_PER_CHAR = 10;
	// Framing bytes
	localparam logic [7:0] FLAG_BYTE = 8'h7E;
	localparam logic [7:0] ESCAPE_BYTE = 8'h7D;
	localparam logic [7:0] ESCAPE_MASK = 8'h20;
	// Check field arithmetic
	localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// Application identifiers
	localparam logic [7:0] APP_ID_CAN_RX = 8'h01;
	localparam logic [7:0] APP_ID_CAN_TX = 8'h02;
	localparam int unsigned EXT_ID_BIT = 29;
	// Buffer
	localparam int unsigned FIFO_DEPTH = 16;

	// One payload byte with its end-of-payload marker
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} pay_word_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPEN = 3'b001,
		ST_BODY = 3'b010,
		ST_CRC_HI = 3'b011,
		ST_CRC_LO = 3'b100,
		ST_CLOSE = 3'b101
	} tx_state_e;
endpackage

//--- src/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("word_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic push, pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) ||
		(wr_ptr_r[AW] == rd_ptr_r[AW]);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign out_data = mem_r[rd_ptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer next values
	always_comb begin
		wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
	end

	// Storage and pointers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			mem_r[wr_ptr_r[AW-1:0]] <= in_data;
	end

	a_no_overflow: assert property (@(posedge clock) disable iff (sys_rst)
		!in_ready |-> (wr_ptr_r - rd_ptr_r) == (AW+1)'(DEPTH))
		else $error("fifo refused a word while not full");
endmodule

//--- verif/host_deframer.sv
`timescale 1ns/1ps
// Host end of the link: UART receive, escape removal, CRC check
module host_deframer
	import frame_pkg::*;
(
	input wire logic clock,
	input wire logic serial_tx,
	output int frames,
	output int pay_len,
	output int bad_stop,
	output logic crc_ok,
	output logic [15:0] rx_crc,
	output logic [7:0] pay_buf [32]
);
	logic [7:0] raw [34];
	logic [7:0] b;
	logic esc;
	int n;

	// Reflected form of 0x8005, zero start, no final inversion
	function automatic logic [15:0] crc16(input int len);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < len; i++) begin
			c ^= {8'h00, raw[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
			end
		end
		return c;
	endfunction

	// Samples mid-bit; a bad stop bit is counted, not fixed up
	initial begin
		frames = 0;
		bad_stop = 0;
		pay_len = 0;
		crc_ok = 1'b0;
		rx_crc = 16'h0000;
		n = 0;
		esc = 1'b0;
		forever begin
			@(negedge serial_tx);
			repeat (BIT_CYCLES / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clock);
				b[i] = serial_tx;
			end
			repeat (BIT_CYCLES) @(posedge clock);
			if (serial_tx !== 1'b1) bad_stop++;
			if (b == FLAG_BYTE) begin
				if (n >= 2) begin
					pay_len = n - 2;
					rx_crc = {raw[n-2], raw[n-1]};
					crc_ok = (crc16(n - 2) === rx_crc);
					for (int i = 0; i < 32; i++) pay_buf[i] = raw[i];
					frames++;
				end
				n = 0;
				esc = 1'b0;
			end else if (b == ESCAPE_BYTE) begin
				esc = 1'b1;
			end else begin
				raw[n] = esc ? b ^ ESCAPE_MASK : b;
				n++;
				esc = 1'b0;
			end
		end
	end
endmodule

//--- verif/serial_frame_codec_test.sv
`timescale 1ns/1ps
module serial_frame_codec_test import frame_pkg::*;;
	typedef struct packed {
		logic [63:0] bytes;
		logic [3:0] len;
		logic [15:0] crc;
	} row_s;
	localparam logic [127:0] FILL = 128'h017E7D00112233445566778899AABBCC;
	row_s rows [2] = '{'{64'hAABBCC7EDDEEFF00, 4'h7, 16'hA384},
		'{64'h027D7E1200000000, 4'h4, 16'h0D30}};
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] pay_data = 8'h00;
	logic pay_last = 1'b0;
	logic pay_valid = 1'b0;
	logic boot_done = 1'b0;
	logic usb_attached = 1'b0;
	logic can_powered = 1'b1;
	logic pay_ready, link_active, serial_tx, frame_sent, crc_ok;
	logic [15:0] rx_crc;
	logic [7:0] pay_buf [32];
	int frames, pay_len, bad_stop;
	int num_errors = 0;
	int total_checks = 0;
	int exp_frames = 0;
	int sent_count = 0;

	serial_frame_codec serial_frame_codec_i (.clock(clock),
		.sys_rst(sys_rst), .pay_data(pay_data), .pay_last(pay_last),
		.pay_valid(pay_valid), .pay_ready(pay_ready),
		.can_powered(can_powered), .boot_done(boot_done),
		.usb_attached(usb_attached), .link_active(link_active),
		.serial_tx(serial_tx), .frame_sent(frame_sent));
	host_deframer host_deframer_i (.clock(clock), .serial_tx(serial_tx),
		.frames(frames), .pay_len(pay_len), .bad_stop(bad_stop),
		.crc_ok(crc_ok), .rx_crc(rx_crc), .pay_buf(pay_buf));

	// 50 ns period
	always #25 clock = ~clock;

	// Counts one-cycle frame pulses, sampled away from the launching edge
	always @(negedge clock) begin
		if (frame_sent === 1'b1) sent_count++;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Valid stays up across bytes so it is never toggled in one step
	task automatic send(input logic [127:0] bytes, input int len);
		for (int i = 0; i < len; i++) begin
			pay_data = bytes[127 - 8 * i -: 8];
			pay_last = (i == len - 1);
			pay_valid = 1'b1;
			while (pay_ready !== 1'b1) @(negedge clock);
			@(negedge clock);
		end
		pay_valid = 1'b0;
	endtask

	task automatic expect_frame(input logic [127:0] bytes, input int len,
		input logic [15:0] crc);
		exp_frames++;
		for (int i = 0; i < 60000 && frames < exp_frames; i++) @(negedge clock);
		check("frames", frames, exp_frames);
		check("pulses", sent_count, exp_frames);
		check("crc_ok", crc_ok, 1'b1);
		check("len", pay_len, len);
		check("stop", bad_stop, 0);
		for (int i = 0; i < len; i++) begin
			check("byte", pay_buf[i], bytes[127 - 8 * i -: 8]);
		end
		if (crc != 16'h0000) check("crc", rx_crc, crc);
	endtask

	task automatic do_reset(input logic usb);
		sys_rst = 1'b1;
		boot_done = 1'b0;
		usb_attached = usb;
		repeat (6) @(negedge clock);
		sys_rst = 1'b0;
		check("ready", pay_ready, 1'b1);
		check("line", serial_tx, 1'b1);
		check("active", link_active, 1'b0);
		check("sent", frame_sent, 1'b0);
		repeat (4) @(negedge clock);
		boot_done = 1'b1;
		repeat (10) @(negedge clock);
	endtask

	// Watchdog sized a little above the full run
	initial begin
		repeat (98000) @(posedge clock);
		num_errors++;
		tally_and_finish();
	end

	// Table rows first, then buffer fill and storage mode
	initial begin
		do_reset(1'b0);
		usb_attached = 1'b1;
		repeat (10) @(negedge clock);
		check("active", link_active, 1'b1);
		foreach (rows[r]) begin
			send({rows[r].bytes, 64'h0}, rows[r].len);
			expect_frame({rows[r].bytes, 64'h0}, rows[r].len, rows[r].crc);
		end
		do_reset(1'b0);
		send(FILL, 16);
		check("full", pay_ready, 1'b0);
		usb_attached = 1'b1;
		expect_frame(FILL, 16, 16'h0000);
		do_reset(1'b1);
		send(FILL, 2);
		repeat (20) @(negedge clock);
		check("active", link_active, 1'b0);
		check("line", serial_tx, 1'b1);
		can_powered = 1'b0;
		do_reset(1'b0);
		usb_attached = 1'b1;
		repeat (10) @(negedge clock);
		check("active", link_active, 1'b0);
		can_powered = 1'b1;
		repeat (10) @(negedge clock);
		check("active", link_active, 1'b1);
		tally_and_finish();
	end
endmodule
